// [rtl/scsev_pack.sv]
// Builds one 32-bit word of an event record in memory byte order.
// Assumes word 0 is the code, words 1-2 the address bytes, word 3 the reason.
`timescale 1ns/10ps
`default_nettype none
module scsev_pack (
  input  wire logic [1:0]  idx,
  input  wire logic [31:0] code,
  input  wire logic [31:0] lun_lo,
  input  wire logic [31:0] lun_hi,
  input  wire logic [31:0] reason,
  input  wire logic        native_be,
  output logic [31:0]      word
);
  // ==========================================================
  // Word select; address bytes are a byte array, never swapped
  always_comb begin
    case (idx)
      2'h0:    word = native_be ? scsev_pkg::bswap(code) : code;
      2'h1:    word = lun_lo;
      2'h2:    word = lun_hi;
      default: word = native_be ? scsev_pkg::bswap(reason) : reason;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/scsev_sense.sv]
// Maps a reported condition to the sense data later commands will see.
// Assumes the caller only acts on valid for reset and parameter events.
`timescale 1ns/10ps
`default_nettype none
module scsev_sense (
  input  wire logic [1:0] kind,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  output logic            valid,
  output logic [3:0]      key,
  output logic [7:0]      asc,
  output logic [7:0]      ascq
);
  // ==========================================================
  // Condition to sense key, asc and qualifier
  always_comb begin
    valid = 1'b1;
    key   = scsev_pkg::KEY_UATTN;
    asc   = lo;
    ascq  = hi;
    case (kind)
      scsev_pkg::EVT_TRESET: begin
        if (lo == scsev_pkg::RST_REMOVED) begin
          key  = scsev_pkg::KEY_ILLEGAL;
          asc  = scsev_pkg::ASC_NOT_SUPP;
          ascq = scsev_pkg::ASCQ_ZERO;
        end else if (lo == scsev_pkg::RST_RESCAN) begin
          asc  = scsev_pkg::ASC_LUNS_CHG;
          ascq = scsev_pkg::ASCQ_LUNS_CHG;
        end else begin
          asc  = scsev_pkg::ASC_RESET;
          ascq = scsev_pkg::ASCQ_ZERO;
        end
      end
      scsev_pkg::EVT_PARAM: valid = 1'b1;
      default: valid = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/scsev_top.sv]
// Event reporter of a SCSI host device: fills driver-posted event buffers.
// Assumes an APB master and a queue front end that presents one buffer at a time.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Record is code, eight address bytes, reason
// - Lost events set bit 31 next record
// - No internal queue; drop events, throttle bus
// - Short buffer returned at once, code zero
// - Lost no-event sent on next new buffer
// - Reset event uses code one, address filled
// - Reason zero hard, one rescan, two removed
// - Rescan/removed only with hotplug negotiated
// - Unit zero rescan/removed means whole target
// - Reset conditions also reported as sense
// - Async code two, reason within subscription
// - Parameter change code three, asc/ascq, attention
// - No parameter change for inquiry type five
// - Legacy mode uses guest native byte order
// - Subscription answered with supported subset
module scsev_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        buf_avail,
  input  wire logic [15:0] buf_len,
  input  wire logic        buf_no_irq,
  output logic             buf_take,
  output logic             wr_valid,
  output logic [1:0]       wr_index,
  output logic [31:0]      wr_data,
  output logic             used_valid,
  output logic [4:0]       used_len,
  output logic             notify,
  output logic             sense_valid,
  output logic [3:0]       sense_key,
  output logic [7:0]       sense_asc,
  output logic [7:0]       sense_ascq,
  output logic [31:0]      sense_lun_lo,
  output logic [31:0]      sense_lun_hi
);
  // ==========================================================
  // State
  typedef enum logic [1:0] {S_IDLE, S_WRITE, S_DONE} scsev_st_t;

  typedef struct packed {
    logic                       pready;     // Access phase answer
    logic                       pslverr;    // Unmapped address
    logic [31:0]                prdata;     // Read data
    logic [scsev_pkg::CTRL_W-1:0] ctrl;     // Mode bits
    logic [15:0]                info_size;  // Event-info size in bytes
    logic [31:0]                subscr;     // Granted async mask
    logic [31:0]                lun_lo;     // Address bytes 0..3
    logic [31:0]                lun_hi;     // Address bytes 4..7
    scsev_st_t                  st;         // Record engine
    logic                       lost;       // Events were dropped
    logic                       carry;      // Current record holds the lost bit
    logic [7:0]                 dropped;    // Drop count, wraps
    logic [7:0]                 suppressed; // Suppressed count, wraps
    logic [31:0]                code;       // Record code word
    logic [31:0]                reason;     // Record reason word
    logic [1:0]                 idx;        // Word being written
    logic [1:0]                 last;       // Final word index
    logic                       wr_valid;
    logic [1:0]                 wr_index;
    logic [31:0]                wr_data;
    logic                       buf_take;
    logic                       used_valid;
    logic [4:0]                 used_len;
    logic                       notify;
    logic                       sense_valid;
    logic [3:0]                 sense_key;
    logic [7:0]                 sense_asc;
    logic [7:0]                 sense_ascq;
    logic [31:0]                sense_lun_lo;
    logic [31:0]                sense_lun_hi;
  } scsev_state_t;

  scsev_state_t s;       // Registered state
  scsev_state_t next_s;  // Next state

  logic [31:0] pack_word;   // Word from the record builder
  logic        sn_valid;    // Sense mapping applies
  logic [3:0]  sn_key;
  logic [7:0]  sn_asc;
  logic [7:0]  sn_ascq;

  // Event register fields of the current write
  logic [7:0] ev_lo;
  logic [7:0] ev_hi;
  logic [1:0] ev_kind;
  logic [4:0] ev_inq;
  assign ev_lo   = pwdata[scsev_pkg::EV_LO_LSB +: 8];
  assign ev_hi   = pwdata[scsev_pkg::EV_HI_LSB +: 8];
  assign ev_kind = pwdata[scsev_pkg::EV_KIND_LSB +: 2];
  assign ev_inq  = pwdata[scsev_pkg::EV_INQ_LSB +: 5];

  // ==========================================================
  // Helpers
  scsev_pack u_pack (
    .idx       (s.idx),
    .code      (s.code),
    .lun_lo    (s.lun_lo),
    .lun_hi    (s.lun_hi),
    .reason    (s.reason),
    .native_be (s.ctrl[scsev_pkg::CTRL_LEGACY] & s.ctrl[scsev_pkg::CTRL_GUEST_BE]),
    .word      (pack_word)
  );

  scsev_sense u_sense (
    .kind  (ev_kind),
    .lo    (ev_lo),
    .hi    (ev_hi),
    .valid (sn_valid),
    .key   (sn_key),
    .asc   (sn_asc),
    .ascq  (sn_ascq)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic       access;    // Access phase waiting for an answer
    logic       commit;    // Edge at which the master takes the answer
    logic       ev_write;  // Commit of a write to the event register
    logic       hotplug;   // Reason needs the hotplug feature
    logic       suppress;  // Event never allowed out
    logic       drop;      // Event lost for want of a buffer
    logic       set_lost;  // Lost flag set this cycle
    logic       clr_lost;  // Lost flag delivered this cycle
    logic       short_buf; // Buffer below the configured size
    logic       mapped;    // Address hits a register
    logic [31:0] rd;       // Read mux
    access   = 1'b0;
    commit   = 1'b0;
    ev_write = 1'b0;
    hotplug  = 1'b0;
    suppress = 1'b0;
    drop     = 1'b0;
    set_lost = 1'b0;
    clr_lost = 1'b0;
    short_buf = 1'b0;
    mapped   = 1'b1;
    rd       = 32'h0000_0000;
    next_s   = s;
    // Pulses last one cycle
    next_s.pready      = 1'b0;
    next_s.buf_take    = 1'b0;
    next_s.wr_valid    = 1'b0;
    next_s.used_valid  = 1'b0;
    next_s.notify      = 1'b0;
    next_s.sense_valid = 1'b0;

    access    = psel & penable & ~s.pready;
    commit    = psel & penable & s.pready;
    short_buf = buf_len < s.info_size;

    // Read mux and decode
    case (paddr)
      scsev_pkg::OFF_CTRL:   rd = {{(32-scsev_pkg::CTRL_W){1'b0}}, s.ctrl};
      scsev_pkg::OFF_INFO:   rd = {16'h0000, s.info_size};
      scsev_pkg::OFF_SUBSCR: rd = s.subscr;
      scsev_pkg::OFF_LUN_LO: rd = s.lun_lo;
      scsev_pkg::OFF_LUN_HI: rd = s.lun_hi;
      scsev_pkg::OFF_EVENT:  rd = 32'h0000_0000;
      scsev_pkg::OFF_STATUS: begin
        rd[scsev_pkg::ST_LOST] = s.lost;
        rd[scsev_pkg::ST_BUSY] = (s.st != S_IDLE);
        rd[scsev_pkg::ST_DROP_LSB +: 8] = s.dropped;
        rd[scsev_pkg::ST_SUPP_LSB +: 8] = s.suppressed;
      end
      default: mapped = 1'b0;
    endcase

    // Answer; an event write waits for the engine, which throttles the source
    if (access && !(pwrite && paddr == scsev_pkg::OFF_EVENT && s.st != S_IDLE)) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = ~mapped;
      next_s.prdata  = pwrite ? 32'h0000_0000 : rd;
    end

    // Register writes take effect at the committing edge only
    if (commit && pwrite && mapped) begin
      case (paddr)
        scsev_pkg::OFF_CTRL:   next_s.ctrl = pwdata[scsev_pkg::CTRL_W-1:0];
        scsev_pkg::OFF_INFO:   next_s.info_size = pwdata[15:0];
        scsev_pkg::OFF_SUBSCR: next_s.subscr = pwdata & scsev_pkg::ASYNC_SUPPORTED;
        scsev_pkg::OFF_LUN_LO: next_s.lun_lo = pwdata;
        scsev_pkg::OFF_LUN_HI: next_s.lun_hi = pwdata;
        scsev_pkg::OFF_EVENT:  ev_write = 1'b1;
        default: ev_write = 1'b0;
      endcase
    end

    // ==========================================================
    // Event admission
    if (ev_write) begin
      hotplug  = (ev_kind == scsev_pkg::EVT_TRESET) && (ev_lo != scsev_pkg::RST_HARD);
      suppress = (hotplug && !s.ctrl[scsev_pkg::CTRL_HOTPLUG])
               | ((ev_kind == scsev_pkg::EVT_PARAM) && (ev_inq == scsev_pkg::INQ_MMC));
      // Reset and parameter conditions also become sense data
      if (sn_valid && !suppress) begin
        next_s.sense_valid  = 1'b1;
        next_s.sense_key    = sn_key;
        next_s.sense_asc    = sn_asc;
        next_s.sense_ascq   = sn_ascq;
        next_s.sense_lun_lo = s.lun_lo;
        next_s.sense_lun_hi = s.lun_hi;
      end
      if (suppress) begin
        next_s.suppressed = s.suppressed + 8'h01;
      end else if (!buf_avail || short_buf) begin
        drop = 1'b1;
        next_s.dropped = s.dropped + 8'h01;
      end else begin
        // Unit zero is passed as written; the driver widens it to the target
        next_s.code   = {30'h0, ev_kind} | (s.lost ? scsev_pkg::EVT_MISSED : 32'h0);
        next_s.carry  = s.lost;
        case (ev_kind)
          scsev_pkg::EVT_TRESET: next_s.reason = {24'h0, ev_lo};
          scsev_pkg::EVT_ASYNC:  next_s.reason = {16'h0, ev_hi, ev_lo} & s.subscr;
          scsev_pkg::EVT_PARAM:  next_s.reason = {16'h0, ev_hi, ev_lo};
          default:               next_s.reason = 32'h0000_0000;
        endcase
        next_s.last     = scsev_pkg::REC_LAST_WORD;
        next_s.idx      = 2'h0;
        next_s.buf_take = 1'b1;
        next_s.st       = S_WRITE;
      end
    end else if (s.st == S_IDLE && !(psel && penable) && buf_avail) begin
      // Buffers that arrive with nothing to report
      if (short_buf) begin
        next_s.code   = s.lost ? scsev_pkg::EVT_MISSED : 32'h0000_0000;
        next_s.carry  = s.lost;
        next_s.reason = 32'h0000_0000;
        next_s.last   = scsev_pkg::SHORT_LAST_WORD;
        next_s.idx    = 2'h0;
        next_s.buf_take = 1'b1;
        next_s.st     = S_WRITE;
      end else if (s.lost && s.ctrl[scsev_pkg::CTRL_EARLY]) begin
        next_s.code   = scsev_pkg::EVT_MISSED;
        next_s.carry  = 1'b1;
        next_s.reason = 32'h0000_0000;
        next_s.last   = scsev_pkg::REC_LAST_WORD;
        next_s.idx    = 2'h0;
        next_s.buf_take = 1'b1;
        next_s.st     = S_WRITE;
      end
    end

    // ==========================================================
    // Record engine
    case (s.st)
      S_IDLE: begin
      end
      S_WRITE: begin
        next_s.wr_valid = 1'b1;
        next_s.wr_index = s.idx;
        next_s.wr_data  = pack_word;
        next_s.idx      = s.idx + 2'h1;
        if (s.idx == s.last) begin
          next_s.st = S_DONE;
        end
      end
      S_DONE: begin
        next_s.used_valid = 1'b1;
        next_s.used_len   = {s.last, 2'b00} + 5'h04;
        next_s.notify     = ~buf_no_irq;
        clr_lost          = s.carry;
        next_s.carry      = 1'b0;
        next_s.st         = S_IDLE;
      end
      default: next_s.st = S_IDLE;
    endcase

    // A drop in the delivery cycle keeps the flag: set wins
    set_lost    = drop;
    next_s.lost = (s.lost & ~clr_lost) | set_lost;
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.st        <= S_IDLE;
      s.info_size <= scsev_pkg::INFO_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign pready       = s.pready;
  assign prdata       = s.prdata;
  assign pslverr      = s.pslverr;
  assign buf_take     = s.buf_take;
  assign wr_valid     = s.wr_valid;
  assign wr_index     = s.wr_index;
  assign wr_data      = s.wr_data;
  assign used_valid   = s.used_valid;
  assign used_len     = s.used_len;
  assign notify       = s.notify;
  assign sense_valid  = s.sense_valid;
  assign sense_key    = s.sense_key;
  assign sense_asc    = s.sense_asc;
  assign sense_ascq   = s.sense_ascq;
  assign sense_lun_lo = s.sense_lun_lo;
  assign sense_lun_hi = s.sense_lun_hi;
endmodule
`default_nettype wire

// [shared/scsev_pkg.sv]
// Constants and the byte-swap function shared by the event reporter and its helpers.
// Assumes one clock domain and an APB register port with 32-bit data.
package scsev_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;  // Feature and mode bits
  localparam logic [7:0] OFF_INFO   = 8'h04;  // Configured event-info size, bytes
  localparam logic [7:0] OFF_SUBSCR = 8'h08;  // Async subscription mask
  localparam logic [7:0] OFF_LUN_LO = 8'h0c;  // Address bytes 0..3
  localparam logic [7:0] OFF_LUN_HI = 8'h10;  // Address bytes 4..7
  localparam logic [7:0] OFF_EVENT  = 8'h14;  // Write raises one event
  localparam logic [7:0] OFF_STATUS = 8'h18;  // Engine state and counters
  // ==========================================================
  // Control bit positions
  localparam int CTRL_HOTPLUG = 0;  // Hotplug feature negotiated
  localparam int CTRL_LEGACY  = 1;  // Legacy interface in use
  localparam int CTRL_GUEST_BE = 2; // Guest native order is big-endian
  localparam int CTRL_EARLY   = 3;  // Send no-event on new buffer after loss
  localparam int CTRL_W       = 4;
  // Event register fields
  localparam int EV_LO_LSB  = 0;   // Reason low byte or asc
  localparam int EV_HI_LSB  = 8;   // Reason high byte or ascq
  localparam int EV_KIND_LSB = 16; // Event code, two bits
  localparam int EV_INQ_LSB = 18;  // Inquiry peripheral type, five bits
  // Status fields
  localparam int ST_LOST = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_DROP_LSB = 8;
  localparam int ST_SUPP_LSB = 16;
  // ==========================================================
  // Record layout and codes
  localparam logic [31:0] EVT_MISSED  = 32'h8000_0000;
  localparam logic [1:0]  EVT_NONE    = 2'h0;
  localparam logic [1:0]  EVT_TRESET  = 2'h1;
  localparam logic [1:0]  EVT_ASYNC   = 2'h2;
  localparam logic [1:0]  EVT_PARAM   = 2'h3;
  localparam logic [7:0]  RST_HARD    = 8'h00;
  localparam logic [7:0]  RST_RESCAN  = 8'h01;
  localparam logic [7:0]  RST_REMOVED = 8'h02;
  localparam logic [4:0]  INQ_MMC     = 5'h05;
  localparam logic [31:0] ASYNC_SUPPORTED = 32'h0000_001a; // Bits 1, 3, 4
  localparam logic [1:0]  REC_LAST_WORD = 2'h3;  // Four words, sixteen bytes
  localparam logic [1:0]  SHORT_LAST_WORD = 2'h0; // Event code only
  localparam logic [15:0] INFO_RESET  = 16'h0010;
  // Sense data
  localparam logic [3:0] KEY_ILLEGAL = 4'h5;
  localparam logic [3:0] KEY_UATTN   = 4'h6;
  localparam logic [7:0] ASC_NOT_SUPP = 8'h25;
  localparam logic [7:0] ASC_RESET   = 8'h29;
  localparam logic [7:0] ASC_LUNS_CHG = 8'h3f;
  localparam logic [7:0] ASCQ_LUNS_CHG = 8'h0e;
  localparam logic [7:0] ASCQ_ZERO   = 8'h00;

  // Byte reversal of one 32-bit field
  function automatic logic [31:0] bswap(input logic [31:0] w);
    bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
endpackage

// [sim/scsev_drv.sv]
// Guest driver model: posts a stock of equal-length event buffers.
// Assumes the bench reloads the stock; one buffer leaves per take.
`timescale 1ns/10ps
`default_nettype none
module scsev_drv (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [3:0]  cnt,
  input  wire logic [15:0] len,
  input  wire logic        no_irq,
  input  wire logic        buf_take,
  output logic             buf_avail,
  output logic [15:0]      buf_len,
  output logic             buf_no_irq
);
  logic [3:0] stock;  // Posted buffers, fifteen at most
  // ==========================================================
  // Stock: a taken buffer leaves the head on the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stock <= 4'h0;
    end else if (load) begin
      stock <= cnt;
    end else if (buf_take && stock != 4'h0) begin
      stock <= stock - 4'h1;
    end
  end
  // Empty queue shows an inverted length, never a stale head
  assign buf_avail  = stock != 4'h0;
  assign buf_len    = buf_avail ? len : ~len;
  // Suppression is a ring-wide flag; it stays valid after the last buffer leaves
  assign buf_no_irq = no_irq;
endmodule
`default_nettype wire

// [sim/scsev_props.sv]
// Port checker for the event reporter.
// Assumes it is bound onto scsev_top; one clock, async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module scsev_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        buf_take,
  input wire logic        wr_valid,
  input wire logic [1:0]  wr_index,
  input wire logic        used_valid,
  input wire logic [4:0]  used_len,
  input wire logic        notify,
  input wire logic        sense_valid,
  input wire logic [3:0]  sense_key,
  input wire logic [7:0]  sense_asc,
  input wire logic [7:0]  sense_ascq
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Event register write committing at this edge
  sequence s_evw;
    psel && penable && pready && pwrite && paddr == scsev_pkg::OFF_EVENT;
  endsequence
  // Last two words then the buffer return
  sequence s_tail;
    wr_valid && wr_index == 2'h2 ##1 wr_valid && wr_index == 2'h3
      ##1 used_valid && used_len == 5'd16;
  endsequence
  // ==========================================================
  // Properties
  AST_ANSWER: assert property ($rose(penable) && psel && paddr != scsev_pkg::OFF_EVENT
    |=> pready) else $error("late register answer");
  AST_UNMAPPED: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access not refused");
  AST_WR_ZERO: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write answer carries data");
  AST_TAKE: assert property (buf_take |=> wr_valid && wr_index == 2'h0)
    else $error("taken buffer not written");
  AST_RECORD: assert property (wr_valid && wr_index == 2'h1 |=> s_tail)
    else $error("record words out of order");
  AST_LEN: assert property (used_valid |-> used_len == 5'd16 || used_len == 5'd4)
    else $error("bad used length");
  AST_NOTIFY: assert property (notify |-> used_valid)
    else $error("notify without return");
  AST_SENSE: assert property (sense_valid |-> sense_key == scsev_pkg::KEY_UATTN
    || (sense_key == scsev_pkg::KEY_ILLEGAL && sense_asc == 8'h25 && sense_ascq == 8'h00))
    else $error("bad sense code");
  AST_PARAM: assert property (s_evw ##0 pwdata[17:16] == 2'h3 && pwdata[22:18] != 5'h05
    |=> sense_valid && sense_asc == $past(pwdata[7:0]) && sense_ascq == $past(pwdata[15:8]))
    else $error("parameter change sense wrong");
  AST_MMC: assert property (s_evw ##0 pwdata[17:16] == 2'h3 && pwdata[22:18] == 5'h05
    |=> !sense_valid) else $error("multimedia change reported");
endmodule
`default_nettype wire

// [sim/scsev_top_bench.sv]
// Self-checking bench for the event reporter.
// Assumes the buffer model in scsev_drv and the checker in scsev_props.
`timescale 1ns/10ps
`default_nettype none
module scsev_top_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        buf_avail, buf_no_irq, buf_take, wr_valid, used_valid, notify;
  logic        sense_valid, load, no_irq;
  logic [7:0]  paddr, sense_asc, sense_ascq;
  logic [31:0] pwdata, prdata, wr_data, sense_lun_lo, sense_lun_hi, rd, lo, hi, s, a;
  logic [15:0] buf_len, len;
  logic [4:0]  used_len;
  logic [3:0]  sense_key, cnt;
  logic [1:0]  wr_index;
  logic [31:0] wq[$];  // Expected record words
  logic [31:0] lq[$];  // Expected used lengths
  logic [31:0] sq[$];  // Expected sense key, asc, ascq
  int          num_errors, n_checks;
  scsev_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .buf_avail, .buf_len, .buf_no_irq, .buf_take, .wr_valid, .wr_index,
    .wr_data, .used_valid, .used_len, .notify, .sense_valid, .sense_key, .sense_asc,
    .sense_ascq, .sense_lun_lo, .sense_lun_hi);
  scsev_drv drv (.pclk, .presetn, .load, .cnt, .len, .no_irq, .buf_take, .buf_avail,
    .buf_len, .buf_no_irq);
  // ==========================================================
  // Clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("Counts: %0d checks, %0d mismatches", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; held until pready is sampled high
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      num_errors++;
      stop_test();
    end
  endtask
  task exp_rec(input logic [31:0] c, input logic [31:0] r);
    wq.push_back(c);
    wq.push_back(lo);
    wq.push_back(hi);
    wq.push_back(r);
    lq.push_back(32'h10);
  endtask
  // Raise one event; all-ones code means no record expected
  task ev(input logic [22:0] v, input logic [31:0] c, r, input logic [19:0] sn);
    if (c !== '1) exp_rec(c, r);
    if (sn !== 20'h0) sq.push_back({12'h0, sn});
    apb(1'b1, scsev_pkg::OFF_EVENT, {9'h0, v});
    repeat (8) @(posedge pclk);
  endtask
  task stock(input logic [3:0] c, input logic [15:0] l);
    @(posedge pclk);
    load <= 1'b1;
    cnt <= c;
    len <= l;
    no_irq <= 1'($urandom_range(1));
    @(posedge pclk);
    load <= 1'b0;
  endtask
  function automatic logic [31:0] sw(input logic [31:0] w);
    sw = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  // ==========================================================
  // Result watcher: oldest note against each result
  always @(posedge pclk) begin
    if (wr_valid === 1'b1) check(wr_data, wq.size() ? wq.pop_front() : 'x);
    if (used_valid === 1'b1) begin
      check(32'(used_len), lq.size() ? lq.pop_front() : 'x);
      check(notify, !no_irq);
    end
    if (sense_valid === 1'b1) begin
      check({12'h0, sense_key, sense_asc, sense_ascq}, sq.size() ? sq.pop_front() : 'x);
      check(sense_lun_lo, lo);
      check(sense_lun_hi, hi);
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, load, cnt, len, no_irq, presetn} = '0;
    num_errors = 0;
    n_checks = 0;
    rd = $urandom(32'hd0011142);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, scsev_pkg::OFF_INFO, 0);
    check(rd, 32'h10);
    apb(1'b0, 8'h1c, 0);
    check(err, 1'b1);
    s = $urandom;
    apb(1'b1, scsev_pkg::OFF_SUBSCR, s);
    apb(1'b0, scsev_pkg::OFF_SUBSCR, 0);
    check(rd, s & 32'h1a);
    lo = $urandom;
    hi = $urandom;
    apb(1'b1, scsev_pkg::OFF_LUN_LO, lo);
    apb(1'b1, scsev_pkg::OFF_LUN_HI, hi);
    stock(4'hf, 16'h10);
    $display("Test registers done");
    ev({7'h01, 16'h0}, 1, 0, 20'h62900);
    for (int h = 0; h < 2; h++) begin
      apb(1'b1, scsev_pkg::OFF_CTRL, h);
      ev({7'h01, 16'h1}, h ? 32'h1 : '1, 1, h ? 20'h63f0e : 0);
      ev({7'h01, 16'h2}, h ? 32'h1 : '1, 2, h ? 20'h52500 : 0);
    end
    a = $urandom;
    ev({7'h02, a[15:0]}, 2, {16'h0, a[15:0]} & s & 32'h1a, 0);
    ev({7'h03, a[15:0]}, 3, {16'h0, a[15:0]}, {4'h6, a[7:0], a[15:8]});
    ev({5'h05, 2'h3, a[15:0]}, '1, 0, 0);
    $display("Test event kinds done");
    stock(4'h0, 16'h10);
    ev({7'h01, 16'h0}, '1, 0, 20'h62900);
    apb(1'b0, scsev_pkg::OFF_STATUS, 0);
    check(rd, 32'h0003_0101);
    stock(4'h1, 16'h10);
    ev({7'h03, a[15:0]}, 32'h8000_0003, {16'h0, a[15:0]}, {4'h6, a[7:0], a[15:8]});
    apb(1'b1, scsev_pkg::OFF_CTRL, 32'h9);
    stock(4'h0, 16'h10);
    ev({7'h01, 16'h0}, '1, 0, 20'h62900);
    {lo, hi} = '0;
    apb(1'b1, scsev_pkg::OFF_LUN_LO, lo);
    apb(1'b1, scsev_pkg::OFF_LUN_HI, hi);
    exp_rec(32'h8000_0000, 0);
    stock(4'h1, 16'h10);
    repeat (10) @(posedge pclk);
    apb(1'b1, scsev_pkg::OFF_CTRL, 32'h1);
    wq.push_back(0);
    lq.push_back(32'h4);
    stock(4'h1, 16'h4);
    repeat (10) @(posedge pclk);
    $display("Test loss and short buffer done");
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, scsev_pkg::OFF_CTRL, 32'h3 | (b << 2));
      stock(4'h1, 16'h10);
      ev({7'h01, 16'h1}, b ? sw(1) : 1, b ? sw(1) : 1, 20'h63f0e);
    end
    $display("Test byte order done");
    check(wq.size() + sq.size() + lq.size(), 0);
    stop_test();
  end
endmodule
bind scsev_top scsev_props chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .buf_take, .wr_valid, .wr_index, .used_valid, .used_len,
  .notify, .sense_valid, .sense_key, .sense_asc, .sense_ascq);
`default_nettype wire
